// [hdl/dmarq_top.sv]
// The implementer's own choices: the address map and the AXI4-Lite register port.
`default_nettype none
module dmarq_top #(
    parameter int NPER = 4,
    parameter int DEPTH = dmarq_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // request sources
    input wire logic [NPER-1:0] periph_irq,
    input wire logic [1:0] external_irq_pin,
    // bus sharing with the cpu
    input wire logic cpu_access_done,
    output logic cpu_slot,
    // transfer items to the mover
    output logic xfer_valid,
    input wire logic xfer_ready,
    output dmarq_pkg::dmarq_xfer_t xfer_item
);
    localparam int XW = $bits(dmarq_pkg::dmarq_xfer_t);
    localparam int CH_BIT = dmarq_pkg::CH_SEL_BIT;

    function automatic dmarq_pkg::dmarq_dec_t decode(input logic [31:0] a);
        dmarq_pkg::dmarq_dec_t d;
        logic [7:0] off;
        d.kind = dmarq_pkg::R_NONE;
        d.ch = a[CH_BIT];
        off = {3'h0, a[4:0]};
        if (a[31:8] != 24'h000000 || a[1:0] != 2'h0) begin
            d.kind = dmarq_pkg::R_NONE;
        end else if (a[7:0] == dmarq_pkg::OFF_SWTRIG) begin
            d.kind = dmarq_pkg::R_SWTRIG;
        end else if (a[7:6] != 2'h0) begin
            d.kind = dmarq_pkg::R_NONE;
        end else if (off == dmarq_pkg::OFF_CTRL) begin
            d.kind = dmarq_pkg::R_CTRL;
        end else if (off == dmarq_pkg::OFF_SRC) begin
            d.kind = dmarq_pkg::R_SRC;
        end else if (off == dmarq_pkg::OFF_DST) begin
            d.kind = dmarq_pkg::R_DST;
        end else if (off == dmarq_pkg::OFF_RELOAD) begin
            d.kind = dmarq_pkg::R_RELOAD;
        end else if (off == dmarq_pkg::OFF_PTR) begin
            d.kind = dmarq_pkg::R_PTR;
        end else if (off == dmarq_pkg::OFF_CNT) begin
            d.kind = dmarq_pkg::R_CNT;
        end
        return d;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            m[15:8] = nw[15:8];
        end
        return m;
    endfunction

    // bus slave state
    logic aw_have_r;
    logic w_have_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_fire;
    dmarq_pkg::dmarq_dec_t wdec;
    dmarq_pkg::dmarq_dec_t rdec;

    // channel state
    logic [1:0] en_r;
    logic [1:0] req_r;
    logic [1:0] fwd_dst_r;
    logic [2:0] sel_r [2];
    logic [15:0] src_r [2];
    logic [15:0] dst_r [2];
    logic [15:0] rld_r [2];
    logic [15:0] ptr_r [2];
    logic [15:0] cnt_r [2];
    logic [1:0] trig;
    logic [1:0] sw_trig;
    logic [1:0] wr_ctrl;
    logic [1:0] start;
    logic [1:0] pend;

    // arbiter
    dmarq_pkg::dmarq_arb_t arb_r;
    logic push;
    logic pick;
    logic fifo_in_ready;
    dmarq_pkg::dmarq_xfer_t push_item;

    // write channel: address and data taken in either order
    assign awready = !aw_have_r && !bvalid_r;
    assign wready = !w_have_r && !bvalid_r;
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wdec = decode(awaddr_r);
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= dmarq_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wdec.kind == dmarq_pkg::R_NONE || wdec.kind == dmarq_pkg::R_PTR ||
                            wdec.kind == dmarq_pkg::R_CNT) ? dmarq_pkg::RESP_SLVERR
                                                           : dmarq_pkg::RESP_OKAY;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    assign arready = !rvalid_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign rdec = decode(araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= dmarq_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= dmarq_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
            case (rdec.kind)
                // enable shows activity; flag mostly reads 0 once served
                dmarq_pkg::R_CTRL: rdata_r <= {26'h0000000, fwd_dst_r[rdec.ch], sel_r[rdec.ch],
                                               req_r[rdec.ch], en_r[rdec.ch]};
                dmarq_pkg::R_SRC: rdata_r <= {16'h0000, src_r[rdec.ch]};
                dmarq_pkg::R_DST: rdata_r <= {16'h0000, dst_r[rdec.ch]};
                dmarq_pkg::R_RELOAD: rdata_r <= {16'h0000, rld_r[rdec.ch]};
                dmarq_pkg::R_PTR: rdata_r <= {16'h0000, ptr_r[rdec.ch]};
                dmarq_pkg::R_CNT: rdata_r <= {16'h0000, cnt_r[rdec.ch]};
                dmarq_pkg::R_SWTRIG: rdata_r <= 32'h00000000;
                default: rresp_r <= dmarq_pkg::RESP_SLVERR;
            endcase
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // per-channel state
    genvar c;
    generate
        for (c = 0; c < dmarq_pkg::NUM_CH; c++) begin : g_ch
            logic wr_sel;
            logic wr_kind_ok;
            assign wr_sel = wr_fire && wdec.ch == 1'(c);
            assign wr_kind_ok = wr_sel && wstrb_r[0];
            assign wr_ctrl[c] = wr_kind_ok && wdec.kind == dmarq_pkg::R_CTRL;
            assign sw_trig[c] = wr_fire && wdec.kind == dmarq_pkg::R_SWTRIG && wstrb_r[0] &&
                                wdata_r[c];
            assign start[c] = push && pick == 1'(c);

            dmarq_trig #(
                .NPER(NPER)
            ) u_trig (
                .aclk(aclk),
                .aresetn(aresetn),
                .sel(sel_r[c]),
                .periph_irq(periph_irq),
                .external_irq_pin(external_irq_pin[c]),
                .sw_trig(sw_trig[c]),
                .trig(trig[c])
            );

            // set wins over both clears; a write of 1 leaves the flag alone
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    req_r[c] <= 1'b0;
                end else begin
                    req_r[c] <= (req_r[c] && !start[c] &&
                                 !(wr_ctrl[c] && !wdata_r[dmarq_pkg::BIT_REQ]))
                                || trig[c];
                end
            end

            // changing the source may fake an edge; software clears after
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel_r[c] <= dmarq_pkg::RST_SEL;
                    fwd_dst_r[c] <= 1'b0;
                end else if (wr_ctrl[c]) begin
                    sel_r[c] <= wdata_r[dmarq_pkg::SEL_LSB +: dmarq_pkg::SEL_W];
                    fwd_dst_r[c] <= wdata_r[dmarq_pkg::BIT_FWD_DST];
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    src_r[c] <= dmarq_pkg::RST_WORD;
                    dst_r[c] <= dmarq_pkg::RST_WORD;
                    rld_r[c] <= dmarq_pkg::RST_WORD;
                end else if (wr_kind_ok || (wr_sel && wstrb_r[1])) begin
                    if (wdec.kind == dmarq_pkg::R_SRC) begin
                        src_r[c] <= merge16(src_r[c], wdata_r, wstrb_r);
                    end else if (wdec.kind == dmarq_pkg::R_DST) begin
                        dst_r[c] <= merge16(dst_r[c], wdata_r, wstrb_r);
                    end else if (wdec.kind == dmarq_pkg::R_RELOAD) begin
                        rld_r[c] <= merge16(rld_r[c], wdata_r, wstrb_r);
                    end
                end
            end

            // enable, pointer and counter; an enable write of 1 always restarts
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    en_r[c] <= 1'b0;
                    ptr_r[c] <= dmarq_pkg::RST_WORD;
                    cnt_r[c] <= dmarq_pkg::RST_WORD;
                end else if (wr_ctrl[c] && wdata_r[dmarq_pkg::BIT_EN]) begin
                    en_r[c] <= 1'b1;
                    ptr_r[c] <= wdata_r[dmarq_pkg::BIT_FWD_DST] ? dst_r[c] : src_r[c];
                    cnt_r[c] <= rld_r[c];
                end else if (wr_ctrl[c]) begin
                    en_r[c] <= 1'b0;
                end else if (start[c]) begin
                    ptr_r[c] <= ptr_r[c] + dmarq_pkg::PTR_STEP;
                    cnt_r[c] <= (cnt_r[c] == 16'h0000) ? 16'h0000 : cnt_r[c] - 16'h0001;
                    if (cnt_r[c] <= 16'h0001) begin
                        en_r[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // arbitration: one channel transfer, then one cpu access
    assign pend = en_r & req_r;
    assign pick = !pend[0];
    assign push = arb_r == dmarq_pkg::ARB_IDLE && pend != 2'b00 && fifo_in_ready;
    assign cpu_slot = arb_r == dmarq_pkg::ARB_CPU;
    assign push_item.ch = pick;
    assign push_item.addr = ptr_r[pick];
    assign push_item.remain = cnt_r[pick];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_r <= dmarq_pkg::ARB_IDLE;
        end else begin
            case (arb_r)
                dmarq_pkg::ARB_IDLE: begin
                    if (push) begin
                        arb_r <= dmarq_pkg::ARB_CPU;
                    end
                end
                default: begin
                    if (cpu_access_done) begin
                        arb_r <= dmarq_pkg::ARB_IDLE;
                    end
                end
            endcase
        end
    end

    dmarq_fifo #(
        .WIDTH(XW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_item),
        .out_valid(xfer_valid),
        .out_ready(xfer_ready),
        .out_data(xfer_item)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_req_set_trig: assert property (trig[0] |=> req_r[0])
        else $error("channel 0 trigger did not set the flag");
    a_req_clr_start: assert property ((start[1] && !trig[1]) |=> !req_r[1])
        else $error("flag not cleared when channel 1 transfer began");
    a_sw_write_one: assert property (
        (wr_ctrl[0] && wdata_r[dmarq_pkg::BIT_REQ] && !req_r[0] && !trig[0]) |=> !req_r[0])
        else $error("software write of 1 raised the flag");
    a_sw_write_zero: assert property (
        (wr_ctrl[1] && !wdata_r[dmarq_pkg::BIT_REQ] && !trig[1]) |=> !req_r[1])
        else $error("software write of 0 did not clear the flag");
    a_both_same: assert property ((trig == 2'b11) |=> (req_r == 2'b11))
        else $error("simultaneous triggers not set together");
    a_ch0_first: assert property (
        (arb_r == dmarq_pkg::ARB_IDLE && pend == 2'b11 && fifo_in_ready) |-> (push && !pick))
        else $error("channel 0 not served first");
    a_cpu_between: assert property (
        push |=> (!push && cpu_slot) throughout (!cpu_access_done)[*1])
        else $error("no cpu access slot after a channel transfer");
    a_cpu_wait: assert property ((cpu_slot && !cpu_access_done) |=> !push)
        else $error("transfer started before the cpu access finished");
    a_enable_reload: assert property (
        (wr_ctrl[0] && wdata_r[dmarq_pkg::BIT_EN]) |=>
        (en_r[0] && cnt_r[0] == $past(rld_r[0]) && ptr_r[0] ==
         ($past(wdata_r[dmarq_pkg::BIT_FWD_DST]) ? $past(dst_r[0]) : $past(src_r[0]))))
        else $error("enable write did not reload pointer and counter");
    a_flag_ignores_en: assert property (
        (trig[1] && !en_r[1]) ##1 !en_r[1] |-> req_r[1])
        else $error("disabled channel flag not set by trigger");
endmodule
`default_nettype wire

// [hdl/dmarq_pkg.sv]
`default_nettype none
package dmarq_pkg;
    localparam int NUM_CH = 2;
    localparam int PTR_W = 16;
    localparam int CNT_W = 16;
    // register map, byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC = 8'h04;
    localparam logic [7:0] OFF_DST = 8'h08;
    localparam logic [7:0] OFF_RELOAD = 8'h0c;
    localparam logic [7:0] OFF_PTR = 8'h10;
    localparam logic [7:0] OFF_CNT = 8'h14;
    localparam logic [7:0] OFF_SWTRIG = 8'h40;
    localparam int CH_SEL_BIT = 5;
    // control register fields
    localparam int BIT_EN = 0;
    localparam int BIT_REQ = 1;
    localparam int SEL_LSB = 2;
    localparam int SEL_W = 3;
    localparam int BIT_FWD_DST = 5;
    // reset values
    localparam logic [2:0] RST_SEL = 3'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // trigger source codes
    localparam logic [2:0] SEL_SW = 3'h0;
    localparam logic [2:0] SEL_EXT_FALL = 3'h1;
    localparam logic [2:0] SEL_EXT_RISE = 3'h2;
    localparam logic [2:0] SEL_EXT_BOTH = 3'h3;
    localparam logic [15:0] PTR_STEP = 16'h0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        R_CTRL = 3'b000,
        R_SRC = 3'b001,
        R_DST = 3'b010,
        R_RELOAD = 3'b011,
        R_PTR = 3'b100,
        R_CNT = 3'b101,
        R_SWTRIG = 3'b110,
        R_NONE = 3'b111
    } dmarq_reg_t;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_CPU = 2'b01
    } dmarq_arb_t;

    typedef struct packed {
        dmarq_reg_t kind;
        logic ch;
    } dmarq_dec_t;

    typedef struct packed {
        logic ch;
        logic [PTR_W-1:0] addr;
        logic [CNT_W-1:0] remain;
    } dmarq_xfer_t;
endpackage
`default_nettype wire

// [hdl/dmarq_fifo.sv]
`default_nettype none
module dmarq_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] count_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;
    logic push;
    logic pop;

    assign in_ready = count_r < (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    // output register refills whenever it is empty or being taken
    assign pop = (count_r != '0) && (!out_valid_r || out_ready);
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_r <= '0;
            rd_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (pop) begin
            out_valid_r <= 1'b1;
            out_data_r <= mem[rd_r];
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [hdl/dmarq_trig.sv]
`default_nettype none
module dmarq_trig #(
    parameter int NPER = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // source selection and inputs
    input wire logic [2:0] sel,
    input wire logic [NPER-1:0] periph_irq,
    input wire logic external_irq_pin,
    input wire logic sw_trig,
    // request: one-cycle pulse for pin edges and software, peripheral line level passed through
    output logic trig
);
    logic pin_prev_r;
    logic rise;
    logic fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= external_irq_pin;
        end
    end

    assign rise = external_irq_pin && !pin_prev_r;
    assign fall = !external_irq_pin && pin_prev_r;

    always_comb begin
        case (sel)
            dmarq_pkg::SEL_SW: trig = sw_trig;
            dmarq_pkg::SEL_EXT_FALL: trig = fall;
            dmarq_pkg::SEL_EXT_RISE: trig = rise;
            dmarq_pkg::SEL_EXT_BOTH: trig = rise || fall;
            // peripheral line taken the same cycle its interrupt flag would set
            default: trig = periph_irq[sel[1:0]];
        endcase
    end

    a_ext_fall_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel == dmarq_pkg::SEL_EXT_FALL && $fell(external_irq_pin)) |-> trig)
        else $error("falling pin edge did not raise the trigger");
    a_periph_same: assert property (@(posedge aclk) disable iff (!aresetn)
        (sel[2] && periph_irq[sel[1:0]]) |-> trig)
        else $error("peripheral request not passed through in the same cycle");
endmodule
`default_nettype wire

// [sim/dmarq_partner.sv]
`default_nettype none
module dmarq_partner (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus sharing
    input wire logic cpu_slot,
    output logic cpu_access_done,
    // transfer stream
    input wire logic stall,
    input wire logic xfer_valid,
    output logic xfer_ready,
    input wire dmarq_pkg::dmarq_xfer_t xfer_item
);
    timeunit 1ns;
    timeprecision 1ps;
    dmarq_pkg::dmarq_xfer_t items[$];
    int n_cpu;
    int wait_c;

    // mover, stalls on request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_ready <= 1'b0;
        end else begin
            xfer_ready <= !stall;
            if (xfer_valid && xfer_ready) begin
                items.push_back(xfer_item);
            end
        end
    end

    // one cpu access per slot, alternately prompt and slow
    always_ff @(posedge aclk) begin
        cpu_access_done <= 1'b0;
        if (!aresetn) begin
            n_cpu <= 0;
            wait_c <= 0;
        end else if (cpu_slot && !cpu_access_done) begin
            if (wait_c >= (n_cpu % 2) * 2) begin
                cpu_access_done <= 1'b1;
                n_cpu <= n_cpu + 1;
                wait_c <= 0;
            end else begin
                wait_c <= wait_c + 1;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tb_dmarq_top.sv]
`default_nettype none
module tb_dmarq_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpu_done, cpu_slot, xv, xr, stall;
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic [1:0] bresp, rresp, pin, rs;
    logic [3:0] irq;
    dmarq_pkg::dmarq_xfer_t xi;
    int error_cnt = 0;
    int num_checks = 0;
    int base;

    dmarq_top u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .periph_irq(irq), .external_irq_pin(pin), .cpu_access_done(cpu_done),
        .cpu_slot, .xfer_valid(xv), .xfer_ready(xr), .xfer_item(xi));
    dmarq_partner u_part (.aclk, .aresetn, .cpu_slot, .cpu_access_done(cpu_done),
        .stall, .xfer_valid(xv), .xfer_ready(xr), .xfer_item(xi));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    function automatic logic [31:0] ra(input logic c, input logic [7:0] o);
        return {24'h0, o} + (c ? 32'h20 : 32'h0);
    endfunction

    function automatic logic [31:0] cv(input logic [2:0] s, input logic e);
        return {27'h0, s, 1'b0, e};
    endfunction

    task automatic rc(input logic c, input logic [31:0] e);
        rd(ra(c, dmarq_pkg::OFF_CTRL));
        chk(d, e);
    endtask

    // select change, then clear any spurious flag
    task automatic ss(input logic c, input logic [2:0] s, input logic e);
        wr(ra(c, dmarq_pkg::OFF_CTRL), cv(s, e));
        wr(ra(c, dmarq_pkg::OFF_CTRL), cv(s, e));
    endtask

    task automatic pulse(input int k);
        irq <= 4'(1 << k);
        @(posedge aclk);
        irq <= 4'h0;
        @(posedge aclk);
    endtask

    task automatic waitn(input int n, input int c);
        for (int i = 0; i < 200 && (u_part.items.size() < n || u_part.n_cpu < c); i++)
            @(posedge aclk);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        $display("[ERR] %0t timeout", $time);
        complete_run();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, stall} <= '0;
        {awaddr, wdata, araddr} <= '0;
        pin <= 2'b00;
        irq <= 4'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(0, 32'h0);
        rd(ra(1, dmarq_pkg::OFF_RELOAD));
        chk(d, 32'h0);
        $display("test reset done");
        wr(ra(0, dmarq_pkg::OFF_SWTRIG), 32'h1);
        rc(0, 32'h2);
        rc(1, 32'h0);
        wr(ra(0, dmarq_pkg::OFF_CTRL), 32'h2);
        rc(0, 32'h2);
        wr(ra(0, dmarq_pkg::OFF_CTRL), 32'h0);
        rc(0, 32'h0);
        wr(ra(0, dmarq_pkg::OFF_CTRL), 32'h2);
        rc(0, 32'h0);
        $display("test flag done");
        for (int s = 1; s < 4; s++) begin
            ss(1, 3'(s), 1'b0);
            pin <= 2'b10;
            repeat (2) @(posedge aclk);
            rc(1, cv(3'(s), 1'b0) | (s != 1 ? 32'h2 : 32'h0));
            wr(ra(1, dmarq_pkg::OFF_CTRL), cv(3'(s), 1'b0));
            pin <= 2'b00;
            repeat (2) @(posedge aclk);
            rc(1, cv(3'(s), 1'b0) | (s != 2 ? 32'h2 : 32'h0));
            wr(ra(1, dmarq_pkg::OFF_CTRL), cv(3'(s), 1'b0));
        end
        for (int k = 0; k < 4; k++) begin
            ss(0, 3'(4 + k), 1'b0);
            pulse((k + 1) % 4);
            rc(0, cv(3'(4 + k), 1'b0));
            pulse(k);
            rc(0, cv(3'(4 + k), 1'b0) | 32'h2);
        end
        $display("test sources done");
        for (int c = 0; c < 2; c++) begin
            wr(ra(c[0], dmarq_pkg::OFF_SRC), 32'h100 << c);
            wr(ra(c[0], dmarq_pkg::OFF_RELOAD), 32'h3);
            ss(c[0], dmarq_pkg::SEL_SW, 1'b1);
        end
        wr(ra(0, dmarq_pkg::OFF_SWTRIG), 32'h3);
        waitn(2, 2);
        chk(u_part.items[0], {1'b0, 16'h0100, 16'h0003});
        chk(u_part.items[1], {1'b1, 16'h0200, 16'h0003});
        chk(u_part.n_cpu, 2);
        rc(0, 32'h1);
        wr(ra(0, dmarq_pkg::OFF_CTRL), 32'h1);
        rd(ra(0, dmarq_pkg::OFF_PTR));
        chk(d, 32'h100);
        rd(ra(0, dmarq_pkg::OFF_CNT));
        chk(d, 32'h3);
        wr(ra(1, dmarq_pkg::OFF_DST), 32'h300);
        wr(ra(1, dmarq_pkg::OFF_CTRL), 32'h21);
        rc(1, 32'h21);
        rd(ra(1, dmarq_pkg::OFF_PTR));
        chk(d, 32'h300);
        $display("test priority done");
        wr(ra(0, dmarq_pkg::OFF_RELOAD), 32'd20);
        wr(ra(0, dmarq_pkg::OFF_CTRL), 32'h1);
        u_part.items.delete();
        base = u_part.n_cpu;
        stall <= 1'b1;
        for (int j = 0; j < 18; j++) begin
            wr(ra(0, dmarq_pkg::OFF_SWTRIG), 32'h1);
            if (j < 17) waitn(0, base + j + 1);
        end
        rc(0, 32'h3);
        stall <= 1'b0;
        waitn(18, base + 18);
        chk(u_part.items.size(), 18);
        rc(0, 32'h1);
        $display("test buffer done");
        rd(32'h3c);
        chk({rs, d}, {dmarq_pkg::RESP_SLVERR, 32'h0});
        wr(ra(0, dmarq_pkg::OFF_PTR), 32'h1);
        chk(rs, dmarq_pkg::RESP_SLVERR);
        $display("test errors done");
        complete_run();
    end
endmodule
`default_nettype wire
